// File: lars_chk.sv
// Assertion checker for the readout sequencer.
module lars_chk #(
  parameter int LEVEL_W = 12,
  parameter int PIXELS = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire logic [LEVEL_W-1:0] pixel_level,
  input wire logic [LEVEL_W-1:0] analog_pixel_output,
  input wire logic analog_out_oe_n,
  input wire logic [PIXELS-1:0] sample_hold_switch,
  input wire logic [PIXELS-1:0] integrator_clear_switch,
  input wire logic [5:0] pixel_index
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic hold_any = |sample_hold_switch;
  wire logic clr_any = |integrator_clear_switch;
  a_hold_one_hot: assert property (hold_any |-> $onehot(sample_hold_switch)) else $error("hold not one-hot");
  a_clear_same_pixel: assert property (clr_any |-> integrator_clear_switch == sample_hold_switch)
    else $error("clear not on held pixel");
  a_hold_at_index: assert property (hold_any |-> sample_hold_switch == (PIXELS'(1) << pixel_index))
    else $error("hold not at index");
  a_clear_release: assert property ($rose(clr_any) |-> clr_any [*5] ##1 !clr_any)
    else $error("clear width wrong");
  a_index_step: assert property ($changed(pixel_index) && pixel_index != 0 |-> pixel_index == $past(pixel_index) + 6'h1)
    else $error("index skipped");
  a_sample_taken: assert property (hold_any && !$stable(sample_hold_switch) |-> ##1
    (analog_pixel_output == pixel_level && !analog_out_oe_n)) else $error("sample not presented");
  a_output_held: assert property ($stable(sample_hold_switch) ##1 $stable(sample_hold_switch)
    |-> $stable(analog_pixel_output) && $stable(analog_out_oe_n)) else $error("output moved in period");
  a_idle_hiz: assert property (!hold_any |-> analog_out_oe_n) else $error("output driven when idle");
  c_first: cover property ($rose(hold_any));
  c_end: cover property ($fell(hold_any));
  c_restart: cover property ($rose(sample_hold_switch[0]) && $past(sample_hold_switch[PIXELS-1]));
endmodule

// File: lars_defs.svh
// Constants for the linear array readout sequencer.
`ifndef LARS_DEFS_SVH
`define LARS_DEFS_SVH

// ----------------------------------------------------------------
// Array geometry.
// ----------------------------------------------------------------
`define LARS_PIXELS 64
`define LARS_PIX_W 6
`define LARS_LAST_PIX 6'h3F
`define LARS_FIRST_PIX 6'h00

// ----------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------
`define LARS_CLK_PERIOD_NS 10
`define LARS_CLEAR_NS 50
`define LARS_CLEAR_CYC ((`LARS_CLEAR_NS + `LARS_CLK_PERIOD_NS - 1) / `LARS_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Widths and reset values.
// ----------------------------------------------------------------
`define LARS_LEVEL_W 12
`define LARS_STAMP_W 32
`define LARS_OUT_RESET 12'h000

`endif

// File: lars_host.sv
// Host model: sensor clock, start pulse and pixel front end.
module lars_host (
  // Clock
  input wire logic clk,
  // Sensor pins
  output logic sclk,
  output logic start,
  // Front end
  input wire logic [5:0] addr,
  output logic [11:0] lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  int now;
  int rise_t;
  assign lvl = {addr, 6'h15};
  initial begin
    sclk = 1'b0;
    start = 1'b0;
    now = 0;
    rise_t = 0;
  end
  // One sensor period of 2h clocks; h is 6 or more, so at most about 8.3 MHz.
  // Frames of 65 periods stay far below 100 us and above 64 periods.
  task automatic pulse(input logic st, input int h);
    start = st;
    repeat (h) @(posedge clk);
    #1 sclk = 1'b1;
    now += h;
    rise_t = now;
    repeat (h) @(posedge clk);
    #1 sclk = 1'b0;
    now += h;
  endtask
endmodule

// File: lars_pkg.sv
// Types shared by the linear array readout sequencer.
package lars_pkg;

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LARS_IDLE = 2'b00,
    LARS_RUN = 2'b01
  } lars_state_t;

endpackage

// File: lars_sequencer.sv
// Readout sequencer of a 64-pixel linear light sensor.
// How it works
// - Start captured: hold pixel 1, clear integrator.
// - CLEAR_CYC clocks later: release clear; next clock period: next pixel.
// - Next clock after pixel 64, start low: output goes high impedance.
// - Integration time is read-to-read interval.
// - Changing clock mid-frame varies pixel integration.
// - Pixel value held for whole clock period.
`include "lars_defs.svh"

module lars_sequencer #(
  parameter int LEVEL_W = `LARS_LEVEL_W,
  parameter int STAMP_W = `LARS_STAMP_W,
  parameter int PIXELS = `LARS_PIXELS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sensor pins from the host
  input wire logic sensor_clk_pin,
  input wire logic start_pin,
  // Pixel front end
  output logic [`LARS_PIX_W-1:0] pixel_level_addr,
  input wire logic [LEVEL_W-1:0] pixel_level,
  // Analog output pin, enable low while driven
  output logic [LEVEL_W-1:0] analog_pixel_output,
  output logic analog_out_oe_n,
  // Pixel switches and status
  output logic [PIXELS-1:0] sample_hold_switch,
  output logic [PIXELS-1:0] integrator_clear_switch,
  output logic [`LARS_PIX_W-1:0] pixel_index,
  output logic [STAMP_W-1:0] integration_cycles,
  output logic integration_known,
  output logic frame_flushed
);

  localparam int CLEAR_CYC = `LARS_CLEAR_CYC;

  lars_pkg::lars_state_t state_r;
  logic sclk_meta_r;
  logic sclk_sync_r;
  logic sclk_prev_r;
  logic start_meta_r;
  logic start_sync_r;
  logic sclk_rise;
  logic go;
  logic frame_end;
  logic [`LARS_PIX_W-1:0] pix_r;
  logic [`LARS_PIX_W-1:0] pix_nxt;
  logic go_d_r;
  logic [STAMP_W-1:0] now_r;
  logic [STAMP_W-1:0] stamp_r;
  logic [STAMP_W-1:0] old_stamp;
  logic [7:0] clear_cnt_r;
  logic [PIXELS-1:0] seen_r;
  logic seen_d_r;

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  function automatic logic [PIXELS-1:0] onehot(input logic [`LARS_PIX_W-1:0] idx);
    logic [PIXELS-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and sensor clock edge.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_meta_r <= 1'b0;
      sclk_sync_r <= 1'b0;
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_meta_r <= sensor_clk_pin;
      sclk_sync_r <= sclk_meta_r;
      sclk_prev_r <= sclk_sync_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      start_meta_r <= 1'b0;
      start_sync_r <= 1'b0;
    end else begin
      start_meta_r <= start_pin;
      start_sync_r <= start_meta_r;
    end
  end

  assign sclk_rise = sclk_sync_r & ~sclk_prev_r;

  // Start wins; otherwise step while a frame runs.
  always_comb begin
    go = 1'b0;
    frame_end = 1'b0;
    pix_nxt = pix_r;
    if (sclk_rise) begin
      if (start_sync_r) begin
        go = 1'b1;
        pix_nxt = `LARS_FIRST_PIX;
      end else if (state_r == lars_pkg::LARS_RUN) begin
        if (pix_r == `LARS_LAST_PIX) begin
          frame_end = 1'b1;
        end else begin
          go = 1'b1;
          pix_nxt = pix_r + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state and pixel pointer.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= lars_pkg::LARS_IDLE;
      pix_r <= `LARS_FIRST_PIX;
    end else begin
      case (state_r)
        lars_pkg::LARS_IDLE: begin
          if (go) begin
            state_r <= lars_pkg::LARS_RUN;
          end
        end
        lars_pkg::LARS_RUN: begin
          if (frame_end) begin
            state_r <= lars_pkg::LARS_IDLE;
          end
        end
        default: begin
          state_r <= lars_pkg::LARS_IDLE;
        end
      endcase
      if (go) begin
        pix_r <= pix_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pixel switches.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      sample_hold_switch <= '0;
      integrator_clear_switch <= '0;
      clear_cnt_r <= 8'h00;
      pixel_index <= `LARS_FIRST_PIX;
      pixel_level_addr <= `LARS_FIRST_PIX;
    end else if (go) begin
      sample_hold_switch <= onehot(pix_nxt);
      integrator_clear_switch <= onehot(pix_nxt);
      clear_cnt_r <= 8'(CLEAR_CYC);
      pixel_index <= pix_nxt;
      pixel_level_addr <= pix_nxt;
    end else begin
      if (frame_end) begin
        sample_hold_switch <= '0;
      end
      if (clear_cnt_r > 8'h01) begin
        clear_cnt_r <= clear_cnt_r - 8'h01;
      end else begin
        clear_cnt_r <= 8'h00;
        integrator_clear_switch <= '0;
      end
      if (frame_end) begin
        integrator_clear_switch <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog output, held for the whole sensor clock period.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      go_d_r <= 1'b0;
      analog_pixel_output <= `LARS_OUT_RESET;
      analog_out_oe_n <= 1'b1;
    end else begin
      go_d_r <= go;
      if (go_d_r) begin
        analog_pixel_output <= pixel_level;
        analog_out_oe_n <= 1'b0;
      end else if (frame_end) begin
        analog_out_oe_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read-to-read integration time of each pixel.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      now_r <= '0;
      stamp_r <= '0;
    end else begin
      now_r <= now_r + 1'b1;
      if (go) begin
        stamp_r <= now_r;
      end
    end
  end

  lars_stamp_mem #(
    .WIDTH(STAMP_W),
    .DEPTH(PIXELS),
    .AW(`LARS_PIX_W)
  ) u_stamp_mem (
    .clk(clk),
    .reset(reset),
    .wr_en(go),
    .wr_addr(pix_nxt),
    .wr_data(now_r),
    .rd_en(go),
    .rd_addr(pix_nxt),
    .rd_data_r(old_stamp)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      seen_r <= '0;
      seen_d_r <= 1'b0;
      integration_cycles <= '0;
      integration_known <= 1'b0;
    end else begin
      if (go) begin
        seen_r <= seen_r | onehot(pix_nxt);
        seen_d_r <= seen_r[pix_nxt];
      end
      if (go_d_r) begin
        integration_cycles <= stamp_r - old_stamp;
        integration_known <= seen_d_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flush status after the first frame that ends without a restart.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_flushed <= 1'b0;
    end else if (frame_end) begin
      frame_flushed <= 1'b1;
    end
  end

endmodule

// File: lars_stamp_mem.sv
// Per-pixel memory of the time each pixel was last read.
module lars_stamp_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port, data one cycle later
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_r
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Storage array.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Registered read, old data on a same-address write.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_r <= '0;
    end else if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end

endmodule

// File: tb_top.sv
// Testbench for the readout sequencer.
`include "lars_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, sclk, start, oe_n, known, flushed;
  logic [5:0] addr, idx;
  logic [11:0] lvl, aout;
  logic [63:0] hold, clr;
  logic [31:0] icyc;
  int err_count, checked;
  int stamp[64];
  bit seen[64];
  lars_sequencer dut_u (.clk(clk), .reset(reset), .sensor_clk_pin(sclk), .start_pin(start),
    .pixel_level_addr(addr), .pixel_level(lvl), .analog_pixel_output(aout), .analog_out_oe_n(oe_n),
    .sample_hold_switch(hold), .integrator_clear_switch(clr), .pixel_index(idx),
    .integration_cycles(icyc), .integration_known(known), .frame_flushed(flushed));
  lars_host host_u (.clk(clk), .sclk(sclk), .start(start), .addr(addr), .lvl(lvl));
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic frame(input int h0, input int h1);
    int hc;
    hc = h0;
    host_u.pulse(1'b1, h0);
    for (int i = 0; i < 64; i++) begin
      chk("index", 64'(idx), 64'(i));
      chk("hold", hold, 64'h1 << i);
      chk("addr", 64'(addr), 64'(i));
      chk("clear", clr, (hc < 3 + `LARS_CLEAR_CYC) ? (64'h1 << i) : 64'h0);
      chk("output", {51'h0, oe_n, aout}, {52'h0, 6'(i), 6'h15});
      chk("known", 64'(known), 64'(seen[i]));
      if (seen[i]) chk("integ", 64'(icyc), 64'(host_u.rise_t - stamp[i]));
      stamp[i] = host_u.rise_t;
      seen[i] = 1'b1;
      hc = i < 32 ? h0 : h1;
      if (i < 63) host_u.pulse(1'b0, hc);
    end
  endtask
  task automatic t_flush();
    frame(6, 6);
    chk("flushed_early", 64'(flushed), 64'h0);
    host_u.pulse(1'b0, 6);
    chk("hiz", {62'h0, oe_n, flushed}, 64'h3);
    chk("hold_off", hold, 64'h0);
    chk("clear_off", clr, 64'h0);
    $display("test flush done");
  endtask
  task automatic t_back_to_back();
    frame(6, 6);
    frame(6, 6);
    $display("test back to back done");
  endtask
  task automatic t_clock_change();
    frame(6, 9);
    repeat (2) host_u.pulse(1'b0, 9);
    chk("idle", {hold[62:0], oe_n}, 64'h1);
    chk("idle_last", 64'(hold[63]), 64'h0);
    $display("test clock change done");
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    t_flush();
    t_back_to_back();
    t_clock_change();
    give_verdict();
  end
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
endmodule
bind lars_sequencer lars_chk #(.LEVEL_W(LEVEL_W), .PIXELS(PIXELS)) chk_u (.clk(clk), .reset(reset),
  .pixel_level(pixel_level), .analog_pixel_output(analog_pixel_output), .analog_out_oe_n(analog_out_oe_n),
  .sample_hold_switch(sample_hold_switch), .integrator_clear_switch(integrator_clear_switch),
  .pixel_index(pixel_index));
